// file: hdl/dcwl_config.sv
`timescale 1ns/1ns
// Behaviour
// - Output divisor code 0..7 gives 1,2,4,8,16,32,64,256.
// - USB PLL bit set bypasses the USB PLL; clear enables it.
// - USB PLL input divider code gives 1,2,3,4,5,6,10,12.
// - Multiplier code gives 15,16,17,18,19,20,21,24.
// - System PLL input divider code gives 1,2,3,4,5,6,10,12.
// - Bit 31 set gives the bus-power pin to the USB module.
// - Bit 30 set gives the USB id pin to the USB module.
// - Bit 29 set allows only one pin-map reconfiguration.
// - Bit 28 set allows only one module-disable reconfiguration.
// - Low sixteen bits of the USB word hold a readable user identifier.
// - Pin-map lock set blocks pin-map register writes.
// - Module-disable lock set blocks module-disable register writes.
// - Lock bits change only after the unlock sequence.
// - Scan port enable bit, reset one, enables the scan port.
// - Tdo-use bit, reset one, selects tdo in two-wire mode.
// - Lock register unimplemented bits read zero, bits 2-1 read one.
// - Identity register is read-only: revision 31-28, part 27-0.
// - USB PLL settings honoured only on USB-capable variants.
module dcwl_config #(
  parameter logic USB_CAPABLE = 1'b1
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_ce,
  input  wire logic [31:0]            i_nv_pll_word,
  input  wire logic [31:0]            i_nv_usb_word,
  input  wire logic [3:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [31:0]                 o_rdata,
  output dcwl_pkg::dcwl_clk_cfg_t     o_clk_cfg,
  output dcwl_pkg::dcwl_pin_ctl_t     o_pin_ctl,
  output logic                        o_pin_map_one_shot,
  output logic                        o_module_disable_one_shot,
  output logic                        o_pin_map_lock,
  output logic                        o_module_disable_lock,
  output logic [31:0]                 o_pin_map_registers,
  output logic [31:0]                 o_module_disable_registers
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] odiv_dec(input logic [2:0] c);
    case (c)
      3'h0:    odiv_dec = 9'h001;
      3'h1:    odiv_dec = 9'h002;
      3'h2:    odiv_dec = 9'h004;
      3'h3:    odiv_dec = 9'h008;
      3'h4:    odiv_dec = 9'h010;
      3'h5:    odiv_dec = 9'h020;
      3'h6:    odiv_dec = 9'h040;
      default: odiv_dec = 9'h100;
    endcase
  endfunction : odiv_dec

  // Shared by both input dividers
  function automatic logic [3:0] idiv_dec(input logic [2:0] c);
    case (c)
      3'h6:    idiv_dec = 4'ha;
      3'h7:    idiv_dec = 4'hc;
      default: idiv_dec = 4'(c) + 4'h1;
    endcase
  endfunction : idiv_dec

  function automatic logic [4:0] mul_dec(input logic [2:0] c);
    case (c)
      3'h7:    mul_dec = 5'h18;
      default: mul_dec = 5'(c) + 5'h0f;
    endcase
  endfunction : mul_dec

  ////////////////////////////////////////////////////////////////////////////
  dcwl_pkg::dcwl_state_t state_reg;
  dcwl_pkg::dcwl_state_t state_next;
  logic                  unlocked;
  logic                  pin_map_wr_ok;
  logic                  mod_dis_wr_ok;

  assign unlocked = (state_reg.unl == dcwl_pkg::UNL_OPEN);

  always_comb
  begin
    state_next = state_reg;
    // A one-shot bit makes the lock sticky once set again after one clear
    pin_map_wr_ok = !state_reg.pin_map_lock;
    mod_dis_wr_ok = !state_reg.module_disable_lock;

    case (state_reg.unl)
      dcwl_pkg::UNL_IDLE:
      begin
        if (i_wr && i_addr == dcwl_pkg::ADDR_UNLOCK && i_wdata == dcwl_pkg::UNLOCK_KEY1)
          state_next.unl = dcwl_pkg::UNL_KEY1;
      end
      dcwl_pkg::UNL_KEY1:
      begin
        // Second key must come on the very next bus write
        if (i_wr)
          state_next.unl = (i_addr == dcwl_pkg::ADDR_UNLOCK &&
                            i_wdata == dcwl_pkg::UNLOCK_KEY2) ?
                           dcwl_pkg::UNL_OPEN : dcwl_pkg::UNL_IDLE;
      end
      dcwl_pkg::UNL_OPEN:
      begin
        // Window closes after any one write so it cannot be left open
        if (i_wr)
          state_next.unl = dcwl_pkg::UNL_IDLE;
      end
      default: state_next.unl = dcwl_pkg::UNL_IDLE;
    endcase

    if (i_wr)
    begin
      case (i_addr)
        dcwl_pkg::ADDR_LOCK_CTRL:
        begin
          state_next.scan_port_enable = i_wdata[dcwl_pkg::SCAN_BIT];
          state_next.two_wire_tdo_use = i_wdata[dcwl_pkg::TDO_BIT];
          if (unlocked)
          begin
            if (!(state_reg.usb_cfg[dcwl_pkg::PM1W_BIT] && state_reg.pin_map_done &&
                  state_reg.pin_map_lock))
              state_next.pin_map_lock = i_wdata[dcwl_pkg::PMLOCK_BIT];
            if (!(state_reg.usb_cfg[dcwl_pkg::MD1W_BIT] && state_reg.mod_dis_done &&
                  state_reg.module_disable_lock))
              state_next.module_disable_lock = i_wdata[dcwl_pkg::MDLOCK_BIT];
            if (state_reg.pin_map_lock && !i_wdata[dcwl_pkg::PMLOCK_BIT])
              state_next.pin_map_done = 1'b1;
            if (state_reg.module_disable_lock && !i_wdata[dcwl_pkg::MDLOCK_BIT])
              state_next.mod_dis_done = 1'b1;
          end
          // Relocking after the single allowed reconfiguration is permanent
          if (unlocked && state_reg.pin_map_done && state_reg.usb_cfg[dcwl_pkg::PM1W_BIT] &&
              !state_reg.pin_map_lock)
            state_next.pin_map_lock = i_wdata[dcwl_pkg::PMLOCK_BIT];
          if (unlocked && state_reg.mod_dis_done && state_reg.usb_cfg[dcwl_pkg::MD1W_BIT] &&
              !state_reg.module_disable_lock)
            state_next.module_disable_lock = i_wdata[dcwl_pkg::MDLOCK_BIT];
        end
        dcwl_pkg::ADDR_PIN_MAP:
        begin
          if (pin_map_wr_ok)
            state_next.pin_map = i_wdata;
        end
        dcwl_pkg::ADDR_MOD_DIS:
        begin
          if (mod_dis_wr_ok)
            state_next.mod_dis = i_wdata;
        end
        default: state_next.pin_map = state_reg.pin_map;
      endcase
    end

    state_next.rdata = '0;
    if (i_rd)
    begin
      case (i_addr)
        dcwl_pkg::ADDR_PLL_CFG:     state_next.rdata = state_reg.pll_cfg;
        dcwl_pkg::ADDR_USB_PIN_CFG: state_next.rdata = state_reg.usb_cfg;
        dcwl_pkg::ADDR_LOCK_CTRL:
        begin
          state_next.rdata = dcwl_pkg::LOCK_CTRL_ONES;
          state_next.rdata[dcwl_pkg::PMLOCK_BIT] = state_reg.pin_map_lock;
          state_next.rdata[dcwl_pkg::MDLOCK_BIT] = state_reg.module_disable_lock;
          state_next.rdata[dcwl_pkg::SCAN_BIT] = state_reg.scan_port_enable;
          state_next.rdata[dcwl_pkg::TDO_BIT] = state_reg.two_wire_tdo_use;
        end
        dcwl_pkg::ADDR_IDENTITY:
          state_next.rdata = {dcwl_pkg::REV_DEFAULT, dcwl_pkg::PART_DEFAULT};
        dcwl_pkg::ADDR_PIN_MAP:     state_next.rdata = state_reg.pin_map;
        dcwl_pkg::ADDR_MOD_DIS:     state_next.rdata = state_reg.mod_dis;
        default:                    state_next.rdata = '0;
      endcase
    end

    // Decoded clock settings
    state_next.clk.pll_out_divisor =
      odiv_dec(state_reg.pll_cfg[dcwl_pkg::ODIV_LSB +: 3]);
    state_next.clk.pll_multiplier =
      mul_dec(state_reg.pll_cfg[dcwl_pkg::MUL_LSB +: 3]);
    state_next.clk.pll_in_divider =
      idiv_dec(state_reg.pll_cfg[dcwl_pkg::IDIV_LSB +: 3]);
    // Non-USB variants report the USB PLL bypassed with a divide of one
    state_next.clk.usb_pll_bypass =
      USB_CAPABLE ? state_reg.pll_cfg[dcwl_pkg::UPLL_BIT] : 1'b1;
    state_next.clk.usb_pll_in_divider = USB_CAPABLE ?
      idiv_dec(state_reg.pll_cfg[dcwl_pkg::UIDIV_LSB +: 3]) : 4'h1;
    state_next.pins.bus_power_pin_owner = state_reg.usb_cfg[dcwl_pkg::VBUS_BIT];
    state_next.pins.usb_id_pin_owner = state_reg.usb_cfg[dcwl_pkg::USB_ID_PIN_BIT];
    state_next.pins.scan_port_enable = state_reg.scan_port_enable;
    state_next.pins.two_wire_tdo_use = state_reg.two_wire_tdo_use;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Words are loaded only at reset, so runtime writes cannot disturb them
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      state_reg                  <= '0;
      state_reg.unl              <= dcwl_pkg::UNL_IDLE;
      state_reg.scan_port_enable <= dcwl_pkg::SCAN_RST;
      state_reg.two_wire_tdo_use <= dcwl_pkg::TDO_RST;
      state_reg.pll_cfg          <= i_nv_pll_word;
      state_reg.usb_cfg          <= i_nv_usb_word;
    end
    else if (i_ce)
      state_reg <= state_next;
  end

  assign o_rdata                    = state_reg.rdata;
  assign o_clk_cfg                  = state_reg.clk;
  assign o_pin_ctl                  = state_reg.pins;
  assign o_pin_map_one_shot         = state_reg.usb_cfg[dcwl_pkg::PM1W_BIT];
  assign o_module_disable_one_shot  = state_reg.usb_cfg[dcwl_pkg::MD1W_BIT];
  assign o_pin_map_lock             = state_reg.pin_map_lock;
  assign o_module_disable_lock      = state_reg.module_disable_lock;
  assign o_pin_map_registers        = state_reg.pin_map;
  assign o_module_disable_registers = state_reg.mod_dis;

endmodule : dcwl_config

// file: shared/dcwl_pkg.sv
package dcwl_pkg;

  // Register map (word offsets chosen for this block)
  localparam logic [3:0] ADDR_PLL_CFG     = 4'h0;
  localparam logic [3:0] ADDR_USB_PIN_CFG = 4'h1;
  localparam logic [3:0] ADDR_LOCK_CTRL   = 4'h2;
  localparam logic [3:0] ADDR_IDENTITY    = 4'h3;
  localparam logic [3:0] ADDR_UNLOCK      = 4'h4;
  localparam logic [3:0] ADDR_PIN_MAP     = 4'h5;
  localparam logic [3:0] ADDR_MOD_DIS     = 4'h6;

  // Unlock keys, written back to back to the unlock register
  localparam logic [31:0] UNLOCK_KEY1 = 32'haa99_6655;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h5566_99aa;

  // Configuration word fields
  localparam int ODIV_LSB  = 16;
  localparam int UPLL_BIT  = 15;
  localparam int UIDIV_LSB = 8;
  localparam int MUL_LSB   = 4;
  localparam int IDIV_LSB  = 0;
  localparam int VBUS_BIT  = 31;
  localparam int USB_ID_PIN_BIT = 30;
  localparam int PM1W_BIT  = 29;
  localparam int MD1W_BIT  = 28;
  localparam int UID_LSB   = 0;

  // Lock control fields
  localparam int PMLOCK_BIT = 13;
  localparam int MDLOCK_BIT = 12;
  localparam int SCAN_BIT   = 3;
  localparam int TDO_BIT    = 0;
  localparam logic [31:0] LOCK_CTRL_ONES = 32'h0000_0006;

  localparam logic       SCAN_RST = 1'b1;
  localparam logic       TDO_RST  = 1'b1;
  localparam logic [3:0] REV_DEFAULT  = 4'h1;        // Arbitrary value
  localparam logic [27:0] PART_DEFAULT = 28'h0a5_5a01; // Arbitrary value

  typedef struct packed {
    logic [8:0] pll_out_divisor;
    logic       usb_pll_bypass;
    logic [3:0] usb_pll_in_divider;
    logic [4:0] pll_multiplier;
    logic [3:0] pll_in_divider;
  } dcwl_clk_cfg_t;

  typedef struct packed {
    logic        bus_power_pin_owner;
    logic        usb_id_pin_owner;
    logic        scan_port_enable;
    logic        two_wire_tdo_use;
  } dcwl_pin_ctl_t;

  typedef enum logic [2:0] {
    UNL_IDLE = 3'b001,
    UNL_KEY1 = 3'b010,
    UNL_OPEN = 3'b100
  } dcwl_unl_t;

  typedef struct packed {
    logic [31:0]   pll_cfg;
    logic [31:0]   usb_cfg;
    logic          pin_map_lock;
    logic          module_disable_lock;
    logic          scan_port_enable;
    logic          two_wire_tdo_use;
    logic          pin_map_done;
    logic          mod_dis_done;
    dcwl_unl_t     unl;
    logic [31:0]   pin_map;
    logic [31:0]   mod_dis;
    logic [31:0]   rdata;
    dcwl_clk_cfg_t clk;
    dcwl_pin_ctl_t pins;
  } dcwl_state_t;

endpackage : dcwl_pkg

// file: tb/dcwl_config_checker.sv
`timescale 1ns/1ns
module dcwl_config_checker (
  input wire logic                    i_sys_clk,
  input wire logic                    i_rstn,
  input wire logic                    i_ce,
  input wire logic [3:0]              i_addr,
  input wire logic [31:0]             i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [31:0]             o_rdata,
  input wire dcwl_pkg::dcwl_clk_cfg_t o_clk_cfg,
  input wire logic                    o_pin_map_one_shot,
  input wire logic                    o_pin_map_lock,
  input wire logic                    o_module_disable_lock,
  input wire logic [31:0]             o_pin_map_registers,
  input wire logic [31:0]             o_module_disable_registers
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////////
  lock_read_a: assert property ($past(i_ce && i_rd && i_addr == 4'h2) |->
    {o_rdata[31:14], o_rdata[11:4], o_rdata[2:1]} == 28'h3 &&
    o_rdata[13:12] == $past({o_pin_map_lock, o_module_disable_lock})) else $error("lock read");
  ident_read_a: assert property ($past(i_ce && i_rd && i_addr == 4'h3) |->
    o_rdata == {dcwl_pkg::REV_DEFAULT, dcwl_pkg::PART_DEFAULT}) else $error("ident read");
  pm_guard_a: assert property (i_ce && i_wr && i_addr == 4'h5 && o_pin_map_lock |=>
    $stable(o_pin_map_registers)) else $error("pin map written while locked");
  pm_write_a: assert property (i_ce && i_wr && i_addr == 4'h5 && !o_pin_map_lock |=>
    o_pin_map_registers == $past(i_wdata)) else $error("pin map write lost");
  md_guard_a: assert property (i_ce && i_wr && i_addr == 4'h6 && o_module_disable_lock |=>
    $stable(o_module_disable_registers)) else $error("module disable written while locked");
  lock_key_a: assert property ($changed({o_pin_map_lock, o_module_disable_lock}) |->
    $past(i_wr && i_addr == 4'h2)) else $error("lock changed without write");
  odiv_legal_a: assert property ($past(i_rstn) && $past(i_rstn, 2) |->
    $onehot(o_clk_cfg.pll_out_divisor) && !o_clk_cfg.pll_out_divisor[7]) else $error("odiv");
  mul_legal_a: assert property ($past(i_rstn) && $past(i_rstn, 2) |->
    o_clk_cfg.pll_multiplier inside {[15:21], 24}) else $error("multiplier");
  one_shot_hold_a: assert property ($past(i_rstn) |-> $stable(o_pin_map_one_shot))
    else $error("config word changed in run");
  cover property (i_wr && i_addr == 4'h2 ##1 $changed(o_pin_map_lock));
  cover property (i_wr && i_addr == 4'h5 && o_pin_map_lock);
  cover property (i_rd && i_addr == 4'h3);
endmodule : dcwl_config_checker

bind dcwl_config dcwl_config_checker u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_clk_cfg(o_clk_cfg), .o_pin_map_one_shot(o_pin_map_one_shot),
  .o_pin_map_lock(o_pin_map_lock), .o_module_disable_lock(o_module_disable_lock),
  .o_pin_map_registers(o_pin_map_registers),
  .o_module_disable_registers(o_module_disable_registers));

// file: tb/dcwl_config_tb.sv
`timescale 1ns/1ns
module dcwl_config_tb;
  logic                    i_sys_clk, i_rstn, i_rd, i_wr, one_pm, one_md, lk_pm, lk_md;
  logic [3:0]              i_addr;
  logic [31:0]             i_wdata, i_nv_pll_word, i_nv_usb_word, o_rdata, pm_regs, md_regs;
  dcwl_pkg::dcwl_clk_cfg_t clk_cfg;
  dcwl_pkg::dcwl_pin_ctl_t pin_ctl;
  int                      fails = 0, n_compared = 0;
  int                      odiv[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  int                      idiv[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
  int                      mul[8] = '{15, 16, 17, 18, 19, 20, 21, 24};

  dcwl_config dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(1'b1),
    .i_nv_pll_word(i_nv_pll_word), .i_nv_usb_word(i_nv_usb_word), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_clk_cfg(clk_cfg),
    .o_pin_ctl(pin_ctl), .o_pin_map_one_shot(one_pm), .o_module_disable_one_shot(one_md),
    .o_pin_map_lock(lk_pm), .o_module_disable_lock(lk_md), .o_pin_map_registers(pm_regs),
    .o_module_disable_registers(md_regs));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(nm, o_rdata, e);
  endtask : rd

  task automatic unlock(input logic [31:0] d);
    wr(4'h4, dcwl_pkg::UNLOCK_KEY1);
    wr(4'h4, dcwl_pkg::UNLOCK_KEY2);
    wr(4'h2, d);
  endtask : unlock

  // Reserved bits are programmed to one, every three-bit field carries the same code
  task automatic rst(input logic [2:0] c);
    i_nv_pll_word <= {13'h1fff, c, c[0], 4'hf, c, 1'b1, c, 1'b1, c};
    i_nv_usb_word <= {c[0], c[1], c[2], c[0], 12'hfff, 13'h0c5a, c};
    i_rstn <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask : rst

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_rd = 1'b0;
    i_wr = 1'b0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    for (int c = 0; c < 8; c++)
    begin
      rst(c[2:0]);
      chk("odiv", 32'(clk_cfg.pll_out_divisor), odiv[c]);
      chk("bypass", 32'(clk_cfg.usb_pll_bypass), c & 1);
      chk("uidiv", 32'(clk_cfg.usb_pll_in_divider), idiv[c]);
      chk("mul", 32'(clk_cfg.pll_multiplier), mul[c]);
      chk("idiv", 32'(clk_cfg.pll_in_divider), idiv[c]);
      chk("owners", {pin_ctl[3:2], one_pm, one_md}, {c[0], c[1], c[2], c[0]});
      rd(4'h0, i_nv_pll_word, "pll word");
      rd(4'h1, i_nv_usb_word, "usb word");
    end
    $display("decode test done");
    i_nv_pll_word <= 32'h0;
    wr(4'h0, 32'h0);
    rd(4'h0, 32'hffff_ffff, "pll held");
    rd(4'h2, 32'h0000_000f, "lock reset");
    chk("scan tdo", pin_ctl[1:0], 2'h3);
    wr(4'h3, 32'h0);
    rd(4'h3, {dcwl_pkg::REV_DEFAULT, dcwl_pkg::PART_DEFAULT}, "ident");
    rd(4'h7, 32'h0, "unmapped");
    $display("register test done");
    wr(4'h5, 32'h1111_1111);
    wr(4'h6, 32'h2222_2222);
    wr(4'h2, 32'h0000_3009);
    rd(4'h2, 32'h0000_000f, "no unlock");
    chk("pm open", pm_regs, 32'h1111_1111);
    chk("md open", md_regs, 32'h2222_2222);
    unlock(32'h0000_3009);
    wr(4'h5, 32'h3333_3333);
    wr(4'h6, 32'h4444_4444);
    rd(4'h2, 32'h0000_300f, "locked");
    chk("pm shut", pm_regs, 32'h1111_1111);
    chk("md shut", md_regs, 32'h2222_2222);
    wr(4'h4, dcwl_pkg::UNLOCK_KEY1);
    wr(4'h4, 32'h0);
    wr(4'h2, 32'h0);
    rd(4'h2, 32'h0000_3006, "aborted");
    unlock(32'h0);
    rd(4'h2, 32'h0000_0006, "cleared");
    chk("scan tdo off", pin_ctl[1:0], 2'h0);
    unlock(32'h0000_3009);
    unlock(32'h0000_0009);
    rd(4'h2, 32'h0000_300f, "one shot");
    $display("lock test done");
    conclude();
  end
endmodule : dcwl_config_tb
